//--- tb/mcu_reset_sequencer_bench.sv
`timescale 1ns/10ps
`define CK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
   $display("FAIL %0t got %h want %h", $time, a, b); end end
module mcu_reset_sequencer_bench;
   reg clk = 0, rst = 1, power_on_reset = 0, low_voltage_reset = 0;
   reg ext_reset_pin_n = 1, watchdog_timeout = 0, halt_mode = 0;
   reg halt_entry_instruction = 0, watchdog_clear_instruction = 0;
   reg [2:0] pwrup_delay_sel = 3'h0;
   wire high_osc_clock, core_reset, sequence_done, timeout_flag_n;
   wire powerdown_flag_n;
   wire [1:0] seq_state;
   wire [7:0] status_flags;
   integer fail_count = 0, comparisons = 0, cyc = 0, n1, n2, i;
   mcu_reset_sequencer #(.PWRUP_CYC_0(20), .PWRUP_CYC_1(30),
      .PWRUP_CYC_2(40), .PWRUP_CYC_3(50), .PWRUP_CYC_4(60))
      u_mcu_reset_sequencer (.*);
   osc_model u_osc_model (.*);
   initial forever #10 clk = ~clk;
   task step; begin @(posedge clk); #2; end endtask
   task flags(input t, input p); begin
      `CK(timeout_flag_n, t)
      `CK(powerdown_flag_n, p)
      `CK(status_flags, {3'h0, t, p, 3'h0})
   end endtask
   // v is {power_on, low_voltage, pin_n, watchdog, halt}
   task ev(input [4:0] v, input t, input p); begin
      {power_on_reset, low_voltage_reset, ext_reset_pin_n,
         watchdog_timeout, halt_mode} = v;
      step;
      {power_on_reset, low_voltage_reset, ext_reset_pin_n,
         watchdog_timeout, halt_mode} = 5'h04;
      step;
      flags(t, p);
   end endtask
   task boot(input [2:0] s, input integer d); begin
      pwrup_delay_sel = s;
      power_on_reset = 1;
      step;
      power_on_reset = 0;
      n1 = 0;
      n2 = 0;
      step;
      `CK(seq_state, 2'h1)
      while (seq_state == 2'h1 && n1 < 400) begin n1++; step; end
      while (seq_state == 2'h2 && n2 < 400) begin n2++; step; end
      `CK(n1 >= d - 1 && n1 <= d + 1, 1'b1)
      `CK(n2 >= 58 && n2 <= 70, 1'b1)
      `CK({core_reset, sequence_done, seq_state}, 4'h7)
      flags(1, 1);
   end endtask
   task instr(input h, input t, input p); begin
      halt_entry_instruction = h;
      watchdog_clear_instruction = ~h;
      step;
      halt_entry_instruction = 0;
      watchdog_clear_instruction = 0;
      step;
      flags(t, p);
   end endtask
   // halt refused before run, then watchdog-clear lifts a cleared timeout
   task clear_wdt; begin
      ev(5'h06, 0, 1);
      instr(1, 0, 1);
      n1 = 0;
      while (seq_state != 2'h3 && n1 < 400) begin n1++; step; end
      `CK(core_reset, 1'b0)
      instr(0, 1, 1);
   end endtask
   task give_verdict; begin
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin fail_count++; give_verdict; end
   end
   initial begin
      repeat (2) @(posedge clk);
      #2 rst = 0;
      for (i = 0; i < 6; i++)
         boot(i == 5 ? 3'h7 : i[2:0], 20 + 10 * (i > 4 ? 4 : i));
      ev(5'h07, 0, 0);
      ev(5'h00, 0, 0);
      ev(5'h01, 1, 1);
      ev(5'h06, 0, 1);
      ev(5'h00, 0, 1);
      ev(5'h0C, 1, 1);
      ev(5'h06, 0, 1);
      ev(5'h16, 1, 1);
      boot(3'h0, 20);
      instr(1, 1, 0);
      instr(0, 1, 1);
      clear_wdt;
      give_verdict;
   end
endmodule // mcu_reset_sequencer_bench

//--- tb/osc_model.sv
`timescale 1ns/10ps
// free-running oscillator at a quarter of clk
module osc_model (
   input wire clk,
   output reg high_osc_clock
);
   reg div_ff = 1'b0;
   initial high_osc_clock = 1'b0;
   always @(posedge clk) begin
      div_ff <= ~div_ff;
      if (div_ff) high_osc_clock <= ~high_osc_clock;
   end
endmodule // osc_model

//--- tb/rst_seq_sva.sv
`timescale 1ns/10ps
module rst_seq_checker (
   input wire clk,
   input wire rst,
   input wire power_on_reset,
   input wire low_voltage_reset,
   input wire ext_reset_pin_n,
   input wire watchdog_timeout,
   input wire halt_mode,
   input wire halt_entry_instruction,
   input wire watchdog_clear_instruction,
   input wire core_reset,
   input wire sequence_done,
   input wire [1:0] seq_state,
   input wire timeout_flag_n,
   input wire powerdown_flag_n,
   input wire [7:0] status_flags
);
   wire sup = power_on_reset | low_voltage_reset;
   wire pin = ~ext_reset_pin_n;
   wire cause = sup | pin | watchdog_timeout;
   wire to = timeout_flag_n;
   wire pd = powerdown_flag_n;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_HOLD: assert property (cause |=> core_reset && seq_state == 2'h0)
      else $error("core not held");
   AST_SUPPLY: assert property (sup |=> to && pd)
      else $error("supply flags");
   AST_PIN_KEEP: assert property (pin && !halt_mode && !sup
      && !watchdog_timeout |=> to == $past(to) && pd == $past(pd))
      else $error("pin flags changed");
   AST_PIN_HALT: assert property (pin && halt_mode |=> to && pd)
      else $error("pin halt flags");
   AST_WDT_RUN: assert property (watchdog_timeout && !halt_mode && !sup
      |=> !to && pd) else $error("watchdog flags");
   AST_WDT_HALT: assert property (watchdog_timeout && halt_mode && !pin
      && !sup |=> !to && !pd) else $error("watchdog halt flags");
   AST_SLEEP: assert property (seq_state == 2'h3 && !cause
      && halt_entry_instruction |=> to && !pd) else $error("halt flags");
   AST_RELEASE: assert property ($fell(core_reset)
      |-> $past(seq_state) == 2'h2 && sequence_done) else $error("release");
   AST_CLEAR: assert property (seq_state == 2'h3 && !cause
      && !halt_entry_instruction && watchdog_clear_instruction |=> to && pd)
      else $error("watchdog clear flags");
   AST_REFUSE: assert property (seq_state != 2'h3 && !cause
      |=> to == $past(to) && pd == $past(pd)) else $error("flags moved idle");
   AST_STATUS: assert property (status_flags == {3'h0, to, pd, 3'h0})
      else $error("status bits");
endmodule // rst_seq_checker
bind mcu_reset_sequencer rst_seq_checker u_rst_seq_checker (.*);

//--- verilog/delay_counter.v
`timescale 1ns/10ps
`include "rst_seq_consts.vh"
// counts enabled ticks up to a target; cleared by clr
module delay_counter #(
   parameter W = 24
) (
   input wire clk,
   input wire rst,
   input wire clr,
   input wire tick,
   input wire [W-1:0] target,
   output reg done
);
   reg [W-1:0] cnt_ff;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= {W{1'b0}};
         done <= 1'b0;
      end else if (clr) begin
         cnt_ff <= {W{1'b0}};
         done <= 1'b0;
      end else if (tick && !done) begin
         cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
         done <= (cnt_ff + {{(W-1){1'b0}}, 1'b1}) >= target;
      end
   end
endmodule // delay_counter

//--- verilog/mcu_reset_sequencer.v
`timescale 1ns/10ps
`include "rst_seq_consts.vh"
module mcu_reset_sequencer #(
   parameter DELAY_W = 24,
   parameter [DELAY_W-1:0] PWRUP_CYC_0 = `US_TO_CYC(`PWRUP_US_0),
   parameter [DELAY_W-1:0] PWRUP_CYC_1 = `US_TO_CYC(`PWRUP_US_1),
   parameter [DELAY_W-1:0] PWRUP_CYC_2 = `US_TO_CYC(`PWRUP_US_2),
   parameter [DELAY_W-1:0] PWRUP_CYC_3 = `US_TO_CYC(`PWRUP_US_3),
   parameter [DELAY_W-1:0] PWRUP_CYC_4 = `US_TO_CYC(`PWRUP_US_4),
   parameter [4:0] OST_CYC = `OST_CYCLES
) (
   input wire clk,
   input wire rst,
   input wire power_on_reset,
   input wire low_voltage_reset,
   input wire ext_reset_pin_n,
   input wire watchdog_timeout,
   input wire halt_mode,
   input wire halt_entry_instruction,
   input wire watchdog_clear_instruction,
   input wire high_osc_clock,
   input wire [`DELAY_SEL_W-1:0] pwrup_delay_sel,
   output reg core_reset,
   output reg sequence_done,
   output reg [1:0] seq_state,
   output reg timeout_flag_n,
   output reg powerdown_flag_n,
   output reg [7:0] status_flags
);
   localparam [1:0] ST_HOLD = 2'h0;
   localparam [1:0] ST_PWRUP = 2'h1;
   localparam [1:0] ST_OST = 2'h2;
   localparam [1:0] ST_RUN = 2'h3;

   // flag events; EV_NONE first, then the rest from highest to lowest priority
   localparam [2:0] EV_NONE = 3'h0;
   localparam [2:0] EV_SUPPLY = 3'h1;
   localparam [2:0] EV_PIN_HALT = 3'h2;
   localparam [2:0] EV_WDT_HALT = 3'h3;
   localparam [2:0] EV_WDT_RUN = 3'h4;
   localparam [2:0] EV_PIN_RUN = 3'h5;
   localparam [2:0] EV_HALT_INSTR = 3'h6;
   localparam [2:0] EV_CLEAR_INSTR = 3'h7;

   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg to_ff;
   reg pd_ff;
   reg nxt_to;
   reg nxt_pd;
   reg [4:0] ost_cnt_ff;
   reg [4:0] nxt_ost_cnt;
   wire any_cause;
   wire supply_cause;
   wire pin_cause;
   wire running;
   wire osc_rise;
   wire ost_last;
   wire pwrup_done;
   wire pwrup_clr;
   wire [DELAY_W-1:0] pwrup_target;
   wire [2:0] flag_event;
   wire [7:0] nxt_status;

   // maps the delay selection onto a cycle count; spare codes take longest
   function [DELAY_W-1:0] pick_delay;
      input [`DELAY_SEL_W-1:0] sel;
      begin
         case (sel)
            3'h0: pick_delay = PWRUP_CYC_0;
            3'h1: pick_delay = PWRUP_CYC_1;
            3'h2: pick_delay = PWRUP_CYC_2;
            3'h3: pick_delay = PWRUP_CYC_3;
            default: pick_delay = PWRUP_CYC_4;
         endcase
      end
   endfunction

   // picks the one event that decides the flags this cycle
   function [2:0] classify_event;
      input supply;
      input pin;
      input wdt;
      input halted;
      input run;
      input halt_instr;
      input clear_instr;
      begin
         if (supply) begin
            classify_event = EV_SUPPLY;
         end else if (pin && halted) begin
            classify_event = EV_PIN_HALT;
         end else if (wdt && halted) begin
            classify_event = EV_WDT_HALT;
         end else if (wdt) begin
            classify_event = EV_WDT_RUN;
         end else if (pin) begin
            classify_event = EV_PIN_RUN;
         end else if (run && halt_instr) begin
            classify_event = EV_HALT_INSTR;
         end else if (run && clear_instr) begin
            classify_event = EV_CLEAR_INSTR;
         end else begin
            classify_event = EV_NONE;
         end
      end
   endfunction

   // places both flags at their status bit positions, other bits zero
   function [7:0] pack_status;
      input to_bit;
      input pd_bit;
      begin
         pack_status = 8'h00;
         pack_status[`STAT_PD_BIT] = pd_bit;
         pack_status[`STAT_TO_BIT] = to_bit;
      end
   endfunction

   assign supply_cause = power_on_reset | low_voltage_reset;
   assign pin_cause = ~ext_reset_pin_n;
   assign any_cause = supply_cause | pin_cause | watchdog_timeout;
   assign running = (state_ff == ST_RUN);
   assign pwrup_target = pick_delay(pwrup_delay_sel);
   assign pwrup_clr = any_cause | (state_ff != ST_PWRUP);
   assign ost_last = osc_rise && (ost_cnt_ff == OST_CYC - 5'h01);
   assign nxt_status = pack_status(nxt_to, nxt_pd);
   assign flag_event = classify_event(supply_cause, pin_cause,
      watchdog_timeout, halt_mode, running, halt_entry_instruction,
      watchdog_clear_instruction);

   delay_counter #(
      .W(DELAY_W)
   ) u_pwrup (
      .clk(clk),
      .rst(rst),
      .clr(pwrup_clr),
      .tick(1'b1),
      .target(pwrup_target),
      .done(pwrup_done)
   );

   osc_edge_detect u_osc (
      .clk(clk),
      .rst(rst),
      .level_in(high_osc_clock),
      .rise_pulse(osc_rise)
   );

   // flag values for the chosen event; no event keeps both
   always @* begin
      nxt_to = to_ff;
      nxt_pd = pd_ff;
      case (flag_event)
         EV_SUPPLY: begin
            nxt_to = 1'b1;
            nxt_pd = 1'b1;
         end
         EV_PIN_HALT: begin
            nxt_to = 1'b1;
            nxt_pd = 1'b1;
         end
         EV_WDT_HALT: begin
            nxt_to = 1'b0;
            nxt_pd = 1'b0;
         end
         EV_WDT_RUN: begin
            nxt_to = 1'b0;
            nxt_pd = 1'b1;
         end
         EV_PIN_RUN: begin
            nxt_to = to_ff;
            nxt_pd = pd_ff;
         end
         EV_HALT_INSTR: begin
            nxt_to = 1'b1;
            nxt_pd = 1'b0;
         end
         EV_CLEAR_INSTR: begin
            nxt_to = 1'b1;
            nxt_pd = 1'b1;
         end
         default: begin
            nxt_to = to_ff;
            nxt_pd = pd_ff;
         end
      endcase
   end

   always @* begin
      nxt_state = state_ff;
      if (any_cause) begin
         nxt_state = ST_HOLD;
      end else begin
         case (state_ff)
            ST_HOLD: begin
               nxt_state = ST_PWRUP;
            end
            ST_PWRUP: begin
               if (pwrup_done) begin
                  nxt_state = ST_OST;
               end
            end
            ST_OST: begin
               if (ost_last) begin
                  nxt_state = ST_RUN;
               end
            end
            ST_RUN: begin
               nxt_state = ST_RUN;
            end
            default: begin
               nxt_state = ST_HOLD;
            end
         endcase
      end
   end

   // oscillator edges only count inside the start-up wait
   always @* begin
      nxt_ost_cnt = ost_cnt_ff;
      if (any_cause || state_ff != ST_OST) begin
         nxt_ost_cnt = 5'h00;
      end else if (osc_rise) begin
         nxt_ost_cnt = ost_cnt_ff + 5'h01;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= ST_HOLD;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ost_cnt_ff <= 5'h00;
      end else begin
         ost_cnt_ff <= nxt_ost_cnt;
      end
   end

   // flags leave reset as after a power-on
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         to_ff <= `FLAG_RESET;
         pd_ff <= `FLAG_RESET;
      end else begin
         to_ff <= nxt_to;
         pd_ff <= nxt_pd;
      end
   end

   // outputs register next values, so they match the internal flops
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         core_reset <= 1'b1;
      end else begin
         core_reset <= (nxt_state != ST_RUN);
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sequence_done <= 1'b0;
      end else begin
         sequence_done <= (nxt_state == ST_RUN);
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         seq_state <= ST_HOLD;
      end else begin
         seq_state <= nxt_state;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         timeout_flag_n <= `FLAG_RESET;
      end else begin
         timeout_flag_n <= nxt_to;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         powerdown_flag_n <= `FLAG_RESET;
      end else begin
         powerdown_flag_n <= nxt_pd;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         status_flags <= 8'h18;
      end else begin
         status_flags <= nxt_status;
      end
   end
endmodule // mcu_reset_sequencer

//--- verilog/osc_edge_detect.v
`timescale 1ns/10ps
`include "rst_seq_consts.vh"
// turns a synchronous oscillator level into a one-cycle rising-edge pulse
module osc_edge_detect (
   input wire clk,
   input wire rst,
   input wire level_in,
   output reg rise_pulse
);
   reg last_ff;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         last_ff <= 1'b0;
         rise_pulse <= 1'b0;
      end else begin
         last_ff <= level_in;
         rise_pulse <= level_in & ~last_ff;
      end
   end
endmodule // osc_edge_detect

//--- verilog/rst_seq_consts.vh
`ifndef RST_SEQ_CONSTS_VH
`define RST_SEQ_CONSTS_VH
// clock rate in kHz
`define CLK_KHZ 50000
// power-up delay choices in microseconds
`define PWRUP_US_0 140
`define PWRUP_US_1 4500
`define PWRUP_US_2 18000
`define PWRUP_US_3 72000
`define PWRUP_US_4 288000
// cycles per microsecond first, so the product stays inside 32 bits
`define US_TO_CYC(us) ((us) * (`CLK_KHZ / 1000))
`define OST_CYCLES 16
`define DELAY_SEL_W 3
// status bit positions
`define STAT_PD_BIT 3
`define STAT_TO_BIT 4
`define FLAG_RESET 1'b1
`endif
